/* core/irq_level_cell.sv */
// One stage of the pending request priority chain
`timescale 1ns/1ps
`default_nettype none

module irq_level_cell
   import irq_map_pkg::*;
#(
   parameter irq_num_t NUM = 5'h00
) (
   input  wire logic       req,
   input  wire irq_level_t level,
   input  wire logic       in_valid,
   input  wire irq_level_t in_level,
   input  wire irq_num_t   in_num,
   output logic            out_valid,
   output irq_level_t      out_level,
   output irq_num_t        out_num
);

   // Own request takes over on a better or equal level; chain runs high number to low
   wire take_own = req && (!in_valid || (level <= in_level));

   assign out_valid = in_valid | req;
   assign out_level = take_own ? level : in_level;
   assign out_num   = take_own ? NUM : in_num;

endmodule

`default_nettype wire

/* core/irq_map_cfg.svh */
// Constants for the interrupt request mapping and vector fetch logic
`ifndef IRQ_MAP_CFG_SVH
`define IRQ_MAP_CFG_SVH

// Request count and field widths
`define IRQ_COUNT        24
`define IRQ_NUM_W        5
`define IRQ_LEVEL_W      2

// Vector table: request 0 upper byte address, each request two bytes lower
`define IRQ_VEC_TOP      16'hFFFA
`define IRQ_VEC_STEP_SH  1

// Request numbers of each source
`define IRQ_EXT0         5'h00
`define IRQ_EXT1         5'h01
`define IRQ_EXT2         5'h02
`define IRQ_EXT3         5'h03
`define IRQ_UART_SIO     5'h04
`define IRQ_CT0_LO       5'h05
`define IRQ_CT0_HI       5'h06
`define IRQ_LIN_RX       5'h07
`define IRQ_LIN_TX       5'h08
`define IRQ_PPG1_LO      5'h09
`define IRQ_PPG1_HI      5'h0A
`define IRQ_UNUSED_A     5'h0B
`define IRQ_PPG0_HI      5'h0C
`define IRQ_PPG0_LO      5'h0D
`define IRQ_CT1_HI       5'h0E
`define IRQ_PPG16        5'h0F
`define IRQ_I2C          5'h10
`define IRQ_UNUSED_B     5'h11
`define IRQ_ADC          5'h12
`define IRQ_TBT          5'h13
`define IRQ_WATCH        5'h14
`define IRQ_UNUSED_C     5'h15
`define IRQ_CT1_LO       5'h16
`define IRQ_FLASH        5'h17

// Reset values
`define IRQ_NUM_RST      5'h00
`define IRQ_LEVEL_RST    2'h3
`define IRQ_ADDR_RST     16'h0000
`define IRQ_BYTE_RST     8'h00

`endif

/* core/irq_map_pkg.sv */
// Types for the interrupt request mapping and vector fetch logic
package irq_map_pkg;

   // Vector fetch sequencer states
   typedef enum logic [1:0] {
      FETCH_IDLE = 2'b00,
      FETCH_HI   = 2'b01,
      FETCH_LO   = 2'b10,
      FETCH_FIN  = 2'b11
   } fetch_state_t;

   typedef logic [4:0] irq_num_t;
   typedef logic [1:0] irq_level_t;

endpackage

/* core/irq_vector_priority_map.sv */
// Interrupt source mapping, same-level priority chain and vector fetch sequencer
`timescale 1ns/1ps
`default_nettype none
`include "irq_map_cfg.svh"

// Functional notes
// - Compound timer 0 lower half drives request 5, whose vector sits at FFF0 and FFF1.
// - Compound timer 0 upper half drives request 6, whose vector sits at FFEE and FFEF.
// - Compound timer 1 upper half drives request 14, whose vector sits at FFDE and FFDF.
// - Compound timer 1 lower half drives request 22, whose vector sits at FFCE and FFCF.
// - Pulse generator 1 lower half drives request 9 (FFE8) and upper half request 10 (FFE6).
// - Pulse generator 0 upper half drives request 12, whose vector sits at FFE2 and FFE3.
// - Pulse generator 0 lower half drives request 13, whose vector sits at FFE0 and FFE1.
// - Every request has a 2-bit level, and on equal level the lowest request number wins.
module irq_vector_priority_map
   import irq_map_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  ext_int_req,
   input  wire logic        uart_sio_req,
   input  wire logic        ct0_lo_req,
   input  wire logic        ct0_hi_req,
   input  wire logic        lin_rx_req,
   input  wire logic        lin_tx_req,
   input  wire logic        ppg1_lo_req,
   input  wire logic        ppg1_hi_req,
   input  wire logic        ppg0_hi_req,
   input  wire logic        ppg0_lo_req,
   input  wire logic        ct1_hi_req,
   input  wire logic        ppg16_req,
   input  wire logic        i2c_req,
   input  wire logic        adc_req,
   input  wire logic        tbt_req,
   input  wire logic        watch_req,
   input  wire logic        ct1_lo_req,
   input  wire logic        flash_req,
   input  wire logic [47:0] level_fields,
   input  wire logic        cpu_ack,
   input  wire logic [7:0]  mem_rdata,
   output logic             irq_pending,
   output irq_num_t         irq_num,
   output irq_level_t       irq_level,
   output logic             mem_rd,
   output logic [15:0]      mem_addr,
   output logic             vec_valid,
   output logic [15:0]      vec_target,
   output irq_num_t         vec_num
);

   // Source to request number mapping
   logic [`IRQ_COUNT-1:0] req;
   always_comb begin
      req = '0;
      req[`IRQ_EXT0]     = ext_int_req[0] | ext_int_req[4];
      req[`IRQ_EXT1]     = ext_int_req[1] | ext_int_req[5];
      req[`IRQ_EXT2]     = ext_int_req[2] | ext_int_req[6];
      req[`IRQ_EXT3]     = ext_int_req[3] | ext_int_req[7];
      req[`IRQ_UART_SIO] = uart_sio_req;
      req[`IRQ_CT0_LO]   = ct0_lo_req;
      req[`IRQ_CT0_HI]   = ct0_hi_req;
      req[`IRQ_LIN_RX]   = lin_rx_req;
      req[`IRQ_LIN_TX]   = lin_tx_req;
      req[`IRQ_PPG1_LO]  = ppg1_lo_req;
      req[`IRQ_PPG1_HI]  = ppg1_hi_req;
      req[`IRQ_UNUSED_A] = 1'b0;
      req[`IRQ_PPG0_HI]  = ppg0_hi_req;
      req[`IRQ_PPG0_LO]  = ppg0_lo_req;
      req[`IRQ_CT1_HI]   = ct1_hi_req;
      req[`IRQ_PPG16]    = ppg16_req;
      req[`IRQ_I2C]      = i2c_req;
      req[`IRQ_UNUSED_B] = 1'b0;
      req[`IRQ_ADC]      = adc_req;
      req[`IRQ_TBT]      = tbt_req;
      req[`IRQ_WATCH]    = watch_req;
      req[`IRQ_UNUSED_C] = 1'b0;
      req[`IRQ_CT1_LO]   = ct1_lo_req;
      req[`IRQ_FLASH]    = flash_req;
   end

   // Priority chain from request 23 down to request 0
   logic       chain_valid [0:`IRQ_COUNT];
   irq_level_t chain_level [0:`IRQ_COUNT];
   irq_num_t   chain_num   [0:`IRQ_COUNT];

   assign chain_valid[`IRQ_COUNT] = 1'b0;
   assign chain_level[`IRQ_COUNT] = `IRQ_LEVEL_RST;
   assign chain_num[`IRQ_COUNT]   = `IRQ_NUM_RST;

   // Cell gi reads stage gi+1, so request 23 sits at the far end of the chain
   // and any lower numbered cell with an equal level takes over from it
   genvar gi;
   generate
      for (gi = 0; gi < `IRQ_COUNT; gi++) begin : g_chain
         irq_level_cell #(
            .NUM(irq_num_t'(gi))
         ) u_cell (
            .req      (req[gi]),
            .level    (level_fields[2*gi +: 2]),
            .in_valid (chain_valid[gi+1]),
            .in_level (chain_level[gi+1]),
            .in_num   (chain_num[gi+1]),
            .out_valid(chain_valid[gi]),
            .out_level(chain_level[gi]),
            .out_num  (chain_num[gi])
         );
      end
   endgenerate

   // Winner of the chain, lowest number on equal level
   wire        win_valid = chain_valid[0];
   irq_level_t win_level;
   irq_num_t   win_num;
   assign win_level = chain_level[0];
   assign win_num   = chain_num[0];

   // Registered outputs and sequencer state
   logic          irq_pending_reg;
   irq_num_t      irq_num_reg;
   irq_level_t    irq_level_reg;
   logic          mem_rd_reg;
   logic [15:0]   mem_addr_reg;
   logic          vec_valid_reg;
   logic [15:0]   vec_target_reg;
   irq_num_t      vec_num_reg;
   logic [7:0]    vec_hi_reg;
   irq_num_t      fetch_num_reg;
   fetch_state_t  state_reg;
   fetch_state_t  state_next;

   // Vector pair address of the request being fetched
   wire [15:0] fetch_offs  = {10'h000, fetch_num_reg, 1'b0};
   wire [15:0] fetch_upper = `IRQ_VEC_TOP - fetch_offs;
   wire [15:0] fetch_lower = fetch_upper | 16'h0001;
   wire [15:0] win_offs    = {10'h000, win_num, 1'b0};
   wire [15:0] win_upper   = `IRQ_VEC_TOP - win_offs;

   // Fetch starts only when the CPU accepts a pending request
   wire start_fetch = (state_reg == FETCH_IDLE) && cpu_ack && irq_pending_reg;

   // Next state of the vector fetch sequencer
   always_comb begin
      case (state_reg)
         FETCH_IDLE: state_next = start_fetch ? FETCH_HI : FETCH_IDLE;
         FETCH_HI:   state_next = FETCH_LO;
         FETCH_LO:   state_next = FETCH_FIN;
         FETCH_FIN:  state_next = FETCH_IDLE;
         default:    state_next = FETCH_IDLE;
      endcase
   end

   // Memory read strobe: upper byte in FETCH_HI, lower byte in FETCH_LO
   // Address holds through FETCH_LO and FETCH_FIN so the last read stays visible
   wire       mem_rd_next   = (state_next == FETCH_HI) || (state_next == FETCH_LO);
   wire [15:0] mem_addr_next = start_fetch ? win_upper :
                               (state_reg == FETCH_HI) ? fetch_lower : mem_addr_reg;

   // Pending request status toward the CPU
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq_pending_reg <= 1'b0;
         irq_num_reg     <= `IRQ_NUM_RST;
         irq_level_reg   <= `IRQ_LEVEL_RST;
      end else begin
         irq_pending_reg <= win_valid;
         irq_num_reg     <= win_num;
         irq_level_reg   <= win_level;
      end
   end

   // Sequencer state and memory port
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_reg     <= FETCH_IDLE;
         mem_rd_reg    <= 1'b0;
         mem_addr_reg  <= `IRQ_ADDR_RST;
         fetch_num_reg <= `IRQ_NUM_RST;
      end else begin
         state_reg    <= state_next;
         mem_rd_reg   <= mem_rd_next;
         mem_addr_reg <= mem_addr_next;
         if (start_fetch) begin
            fetch_num_reg <= win_num;                            // Latched so a change cannot split the pair
         end
      end
   end

   // Byte capture: upper byte first, lower byte completes the vector
   always_ff @(posedge clk) begin
      if (!rstn) begin
         vec_hi_reg     <= `IRQ_BYTE_RST;
         vec_valid_reg  <= 1'b0;
         vec_target_reg <= `IRQ_ADDR_RST;
         vec_num_reg    <= `IRQ_NUM_RST;
      end else begin
         vec_valid_reg <= (state_reg == FETCH_FIN);
         if (state_reg == FETCH_LO) begin
            vec_hi_reg <= mem_rdata;
         end
         if (state_reg == FETCH_FIN) begin
            vec_target_reg <= {vec_hi_reg, mem_rdata};
            vec_num_reg    <= fetch_num_reg;
         end
      end
   end

   // Output drive
   assign irq_pending = irq_pending_reg;
   assign irq_num     = irq_num_reg;
   assign irq_level   = irq_level_reg;
   assign mem_rd      = mem_rd_reg;
   assign mem_addr    = mem_addr_reg;
   assign vec_valid   = vec_valid_reg;
   assign vec_target  = vec_target_reg;
   assign vec_num     = vec_num_reg;

endmodule

`default_nettype wire

/* verif/irq_vec_mem_model.sv */
// Vector memory model with one cycle read latency
`timescale 1ns/1ps
`default_nettype none
module irq_vec_mem_model (
   input  wire logic       clk,
   input  wire logic       mem_rd,
   input  wire logic [15:0] mem_addr,
   output var logic [7:0]  mem_rdata
);
   // Byte is inverted low address; outside reads the bus wanders
   initial mem_rdata = 8'h00;
   always @(posedge clk) begin
      mem_rdata <= mem_rd ? ~mem_addr[7:0] : mem_rdata + 8'h3B;
   end
endmodule
`default_nettype wire

/* verif/irq_vector_priority_map_properties.sv */
// Port checker for the request mapping, priority and vector fetch logic
`timescale 1ns/1ps
`default_nettype none
module irq_map_checker
   import irq_map_pkg::*;
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        ct0_lo_req,
   input wire logic [47:0] level_fields,
   input wire logic        irq_pending,
   input wire irq_num_t    irq_num,
   input wire irq_level_t  irq_level,
   input wire logic        mem_rd,
   input wire logic [15:0] mem_addr,
   input wire logic        vec_valid,
   input wire irq_num_t    vec_num
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Fetch timing and addressing
   property p_rd_two; $rose(mem_rd) |=> mem_rd ##1 !mem_rd; endproperty
   a_rd_two: assert property (p_rd_two) else $error("fetch read not two cycles");
   property p_hi_even; $rose(mem_rd) |-> !mem_addr[0] && mem_addr >= 16'hFFCC; endproperty
   a_hi_even: assert property (p_hi_even) else $error("upper byte address not even");
   property p_lo_next; mem_rd && $past(mem_rd) |-> mem_addr == $past(mem_addr) + 16'h0001; endproperty
   a_lo_next: assert property (p_lo_next) else $error("lower byte address not next");
   property p_vec_lat; $rose(mem_rd) |-> ##3 vec_valid ##1 !vec_valid; endproperty
   a_vec_lat: assert property (p_vec_lat) else $error("vector ready pulse misplaced");
   property p_vec_addr; vec_valid |-> $past(mem_addr, 3) == 16'hFFFA - {10'h000, vec_num, 1'b0}; endproperty
   a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong for number");
   // Mapping and priority
   property p_ct0; $past(rstn) && $past(ct0_lo_req) && $past(level_fields[11:10]) == 2'h0
      |-> irq_pending && irq_level == 2'h0 && irq_num <= 5'h05; endproperty
   a_ct0: assert property (p_ct0) else $error("timer 0 lower request lost");
   property p_unused; irq_pending |-> !(irq_num inside {5'h0B, 5'h11, 5'h15}); endproperty
   a_unused: assert property (p_unused) else $error("unused request won");
   property p_lvl; $past(rstn) && irq_pending |-> irq_level == 2'($past(level_fields) >> {irq_num, 1'b0});
   endproperty
   a_lvl: assert property (p_lvl) else $error("winner level mismatch");
endmodule
bind irq_vector_priority_map irq_map_checker u_chk (.clk(clk), .rstn(rstn), .ct0_lo_req(ct0_lo_req),
   .level_fields(level_fields), .irq_pending(irq_pending), .irq_num(irq_num), .irq_level(irq_level),
   .mem_rd(mem_rd), .mem_addr(mem_addr), .vec_valid(vec_valid), .vec_num(vec_num));
`default_nettype wire

/* verif/test_irq_vector_priority_map.sv */
// Self-checking bench for the request mapping and vector fetch logic
`timescale 1ns/1ps
`default_nettype none
module test_irq_vector_priority_map;
   import irq_map_pkg::*;
   logic        clk = 1'b0, rstn = 1'b0, cpu_ack = 1'b0;
   logic [23:0] req_m = 24'h0, m;
   logic [7:0]  ext_r = 8'h00, mem_rdata, e;
   logic [47:0] lv = 48'h0;
   wire         irq_pending, mem_rd, vec_valid;
   irq_num_t    irq_num, vec_num;
   irq_level_t  irq_level;
   wire [15:0]  mem_addr, vec_target;
   int          err_count = 0, samples_checked = 0;
   always #50 clk = ~clk;
   irq_vector_priority_map DUT (.clk(clk), .rstn(rstn), .ext_int_req(ext_r), .uart_sio_req(req_m[4]),
      .ct0_lo_req(req_m[5]), .ct0_hi_req(req_m[6]), .lin_rx_req(req_m[7]), .lin_tx_req(req_m[8]),
      .ppg1_lo_req(req_m[9]), .ppg1_hi_req(req_m[10]), .ppg0_hi_req(req_m[12]), .ppg0_lo_req(req_m[13]),
      .ct1_hi_req(req_m[14]), .ppg16_req(req_m[15]), .i2c_req(req_m[16]), .adc_req(req_m[18]),
      .tbt_req(req_m[19]), .watch_req(req_m[20]), .ct1_lo_req(req_m[22]), .flash_req(req_m[23]),
      .level_fields(lv), .cpu_ack(cpu_ack), .mem_rdata(mem_rdata), .irq_pending(irq_pending),
      .irq_num(irq_num), .irq_level(irq_level), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .vec_valid(vec_valid), .vec_target(vec_target), .vec_num(vec_num));
   irq_vec_mem_model u_mem (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
   // Expected {pending, level, number}: lowest level, then lowest number
   function automatic logic [7:0] win(input logic [23:0] mk, input logic [47:0] l);
      logic [7:0] r;
      r = 8'h60;
      for (int i = 23; i >= 0; i--) begin
         if (mk[i] && (!r[7] || l[2*i+:2] <= r[6:5])) r = {1'b1, l[2*i+:2], 5'(i)};
      end
      return r;
   endfunction
   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] sn);
      samples_checked++;
      if (sn !== ex) begin
         $display("BAD %s expected %h seen %h", nm, ex, sn);
         err_count++;
      end
   endtask
   // Apply requests; external ones go to either channel of the shared pair
   task automatic drive(input logic [23:0] mk, input logic [47:0] l);
      @(negedge clk);
      req_m = mk;
      ext_r = $urandom_range(1) ? {mk[3:0], 4'h0} : {4'h0, mk[3:0]};
      lv = l;
      @(negedge clk);
      e = win(mk, l);
      chk("pending", 16'(e[7]), 16'(irq_pending));
      chk("number", 16'(e[4:0]), 16'(irq_num));
      chk("level", 16'(e[6:5]), 16'(irq_level));
   endtask
   // Upper vector address: listed values for the timer and pulse requests, two-byte steps elsewhere
   function automatic logic [15:0] exp_upper(input logic [4:0] n);
      case (n)
         5'h05:   return 16'hFFF0;
         5'h06:   return 16'hFFEE;
         5'h09:   return 16'hFFE8;
         5'h0A:   return 16'hFFE6;
         5'h0C:   return 16'hFFE2;
         5'h0D:   return 16'hFFE0;
         5'h0E:   return 16'hFFDE;
         5'h16:   return 16'hFFCE;
         default: return 16'hFFFA - {10'h000, n, 1'b0};
      endcase
   endfunction
   task automatic fetch(input logic [4:0] n);
      logic [15:0] a;
      a = exp_upper(n);
      cpu_ack = 1'b1;
      @(negedge clk);
      cpu_ack = 1'b0;
      chk("rd_hi", 16'h1, 16'(mem_rd));
      chk("addr_hi", a, mem_addr);
      @(negedge clk);
      chk("addr_lo", a + 16'h1, mem_addr);
      chk("rd_lo", 16'h1, 16'(mem_rd));
      @(negedge clk);
      chk("rd_end", 16'h0, 16'(mem_rd));
      @(negedge clk);
      chk("valid", 16'h1, 16'(vec_valid));
      chk("target", {~a[7:0], ~(a[7:0] + 8'h01)}, vec_target);
      chk("vec_num", 16'(n), 16'(vec_num));
   endtask
   task automatic summarize;
      $display("checked %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      summarize();
   end
   initial begin
      void'($urandom(32'h2973));
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      // Acknowledge with nothing pending is ignored
      drive(24'h0, 48'h0);
      cpu_ack = 1'b1;
      @(negedge clk);
      cpu_ack = 1'b0;
      chk("no_rd", 16'h0, 16'(mem_rd));
      // Each source alone, vector fetched
      for (int i = 0; i < 24; i++) begin
         if (24'hDDF7FF >> i & 1) begin
            drive(24'h1 << i, 48'({$urandom, $urandom}));
            fetch(5'(i));
         end
      end
      // All on one level, then request 23 alone at the best level, then 22 and 23 tied there
      drive(24'hDDF7FF, 48'h0);
      fetch(5'h00);
      drive(24'hDDF7FF, 48'h3FFFFFFFFFFF);
      fetch(5'h17);
      drive(24'hDDF7FF, 48'h3FFFFFFFFFFF >> 2);
      fetch(5'h16);
      // Reset in the middle of a fetch returns every output to its reset value
      drive(24'h000020, 48'h0);
      cpu_ack = 1'b1;
      @(negedge clk);
      cpu_ack = 1'b0;
      rstn = 1'b0;
      @(negedge clk);
      chk("rst_pending", 16'h0, 16'(irq_pending));
      chk("rst_number", 16'h0, 16'(irq_num));
      chk("rst_level", 16'h3, 16'(irq_level));
      chk("rst_rd", 16'h0, 16'(mem_rd));
      chk("rst_addr", 16'h0, mem_addr);
      chk("rst_valid", 16'h0, 16'(vec_valid));
      chk("rst_target", 16'h0, vec_target);
      chk("rst_vec_num", 16'h0, 16'(vec_num));
      rstn = 1'b1;
      // Random mixes
      for (int k = 0; k < 150; k++) begin
         m = 24'($urandom) & 24'hDDF7FF;
         drive(m, 48'({$urandom, $urandom}));
         if (e[7] && k % 4 == 0) fetch(e[4:0]);
      end
      summarize();
   end
endmodule
`default_nettype wire
